/* File: verilog/otp_option_consts.svh */
`ifndef OTP_OPTION_CONSTS_SVH
`define OTP_OPTION_CONSTS_SVH

// ------------------------------------------------------------
// option byte layout
// ------------------------------------------------------------
`define OPT_BYTES        7
`define OPT_LAST_ADDR    15'h0006
`define OPT_BLANK        8'hff
`define OPT_IDX_SYS      0
`define OPT_IDX_P1       1
`define OPT_IDX_P3       2
`define OPT_IDX_P4       3
`define OPT_IDX_P7LO     5
`define OPT_IDX_P7HI     6
`define OPT_IDX_P0       6
`define OPT_OSC_LSB      0
`define OPT_POR_BIT      2
`define OPT_RSTPIN_BIT   3
`define OPT_P0LO_BIT     2
`define OPT_P0HI_BIT     3

// ------------------------------------------------------------
// address mapping between programming and single-chip view
// ------------------------------------------------------------
`define PROG_OFFSET      16'h8000

// ------------------------------------------------------------
// stabilization waits in source oscillator periods
// ------------------------------------------------------------
`define OSC_WAIT_CODE0   19'h00010
`define OSC_WAIT_CODE1   19'h04000
`define OSC_WAIT_14      16384
`define OSC_WAIT_17      131072
`define OSC_WAIT_18      262144

`endif

/* File: verilog/otp_option_pkg.sv */
package otp_option_pkg;

	// ------------------------------------------------------------
	// decoded configuration
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] oscSel;
		logic       resetPinEn;
		logic       porEn;
		logic [7:0] pull0En;
		logic [7:0] pull1En;
		logic [7:0] pull3En;
		logic [7:0] pull4En;
		logic [6:0] pull7En;
	} cfg_s;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT_POR,
		PH_WAIT_STOP
	} phase_e;

	// programmer pins after filtering
	typedef struct packed {
		logic        mode;
		logic        strobeN;
		logic        readN;
		logic        sigReq;
		logic [14:0] addr;
		logic [7:0]  data;
	} prog_pins_s;

endpackage : otp_option_pkg

/* File: verilog/pin_sync3.sv */
`timescale 1ns/1ps

// three-stage pin synchronizer; output moves only once stages two and three agree
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] resetVal,
	output logic      [WIDTH-1:0] pinOut
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_s;

	sync_s st_ff;
	sync_s nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pinIn;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.out[i] = st_ff.s3[i];
			end
		end
		if (!resetn) begin
			nxt_st = {4{resetVal}};
		end
	end

	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	assign pinOut = st_ff.out;

endmodule : pin_sync3

/* File: verilog/osc_wait_timer.sv */
`timescale 1ns/1ps
`include "otp_option_consts.svh"

// counts the selected number of source oscillator periods after a start pulse
module osc_wait_timer #(
	parameter int WAIT_14 = `OSC_WAIT_14,
	parameter int WAIT_17 = `OSC_WAIT_17,
	parameter int WAIT_18 = `OSC_WAIT_18
) (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       start,
	input  wire logic [1:0] sel,
	output logic            done
);

	typedef struct packed {
		logic        busy;
		logic [18:0] cnt;
		logic        done;
	} tmr_s;

	tmr_s st_ff;
	tmr_s nxt_st;
	logic [18:0] limit;

	always_comb begin
		case (sel)
			2'h0:    limit = `OSC_WAIT_CODE0;
			2'h1:    limit = 19'(WAIT_14);
			2'h2:    limit = 19'(WAIT_17);
			default: limit = 19'(WAIT_18);
		endcase
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (start) begin
			// a new start restarts the full wait
			nxt_st.busy = 1'b1;
			nxt_st.cnt  = limit - 19'h00001;
		end else if (st_ff.busy) begin
			if (st_ff.cnt == 19'h00000) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt - 19'h00001;
			end
		end
		if (!resetn) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	assign done = st_ff.done;

endmodule : osc_wait_timer

/* File: verilog/one_time_prog_memory_option_decode.sv */
`timescale 1ns/1ps
`include "otp_option_consts.svh"

// ------------------------------------------------------------
// Summary of operation
// - the seven option bytes sit at programming addresses 0000h to 0006h and the programmer writes option data there.
// - in programming mode addresses 0007h to 7FFFh reach single-chip program locations 8007h to FFFFh, offset 8000h.
// - bits 1:0 of option byte 0 pick a wait of 2^4, 2^14, 2^17 or 2^18 oscillator periods for codes 00 to 11.
// - option byte 0 bit 3 high enables the reset pin and bit 2 high enables power-on reset; zero removes each.
// - port pull-up bits attach the pull-up when zero: byte 1 port 1, byte 2 port 3, byte 3 port 4, bytes 5 and 6 port 7.
// - byte 6 bit 2 controls port 0 pins 0 to 3 and bit 3 pins 4 to 7, zero enabling the pull-ups.
// - every option bit is one when blank, so a blank part has no pull-ups, both resets and the longest wait.
// - vacant option bits read back one unless zero was programmed, and the programmer never programs zero there.
// - the selected wait is applied after power-on reset and on wake-up from stop, also with an external clock.
// - programming mode has no signature read and the programmer must not rely on one.
// ------------------------------------------------------------
module one_time_prog_memory_option_decode #(
	parameter int WAIT_14 = `OSC_WAIT_14,
	parameter int WAIT_17 = `OSC_WAIT_17,
	parameter int WAIT_18 = `OSC_WAIT_18
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// cell array blank state (erase of the one-time array)
	input  wire logic        otpBlankn,
	// programmer pins
	input  wire logic        progModePin,
	input  wire logic        progStrobePinN,
	input  wire logic        progReadPinN,
	input  wire logic        progSigReqPin,
	input  wire logic [14:0] progAddrPin,
	input  wire logic [7:0]  progDataPinIn,
	output logic      [7:0]  progDataPinOut,
	output logic             progDataPinOe,
	// program array beyond the option bytes
	output logic      [15:0] memAddr,
	output logic      [7:0]  memWdata,
	output logic             memWe,
	output logic             memRe,
	input  wire logic [7:0]  memRdata,
	// reset and clock logic
	input  wire logic        resetPinN,
	input  wire logic        powerOnPin,
	input  wire logic        stopWake,
	output logic             resetReq,
	output logic             oscStable,
	output logic      [1:0]  oscWaitSel,
	output logic             resetPinEn,
	output logic             porEn,
	// pad pull-up enables, high attaches the resistor
	output logic      [7:0]  pull0En,
	output logic      [7:0]  pull1En,
	output logic      [7:0]  pull3En,
	output logic      [7:0]  pull4En,
	output logic      [6:0]  pull7En
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`OPT_BYTES-1:0][7:0] optMem;
		otp_option_pkg::cfg_s       cfg;
		otp_option_pkg::phase_e     phase;
		logic                       strobePrev;
		logic                       porPrev;
		logic                       rdFromOpt;
		logic [2:0]                 rdIdx;
		logic                       rdSig;
		logic [15:0]                memAddr;
		logic [7:0]                 memWdata;
		logic                       memWe;
		logic                       memRe;
		logic [7:0]                 progDataOut;
		logic                       progDataOe;
		logic                       resetReq;
		logic                       oscStable;
		logic                       waitStart;
	} state_s;

	state_s                    st_ff;
	state_s                    nxt_st;
	otp_option_pkg::prog_pins_s pins;
	logic [1:0]                ctlSync;
	logic                      waitDone;

	// ------------------------------------------------------------
	// pin synchronizers
	// ------------------------------------------------------------
	pin_sync3 #(
		.WIDTH($bits(otp_option_pkg::prog_pins_s))
	) u_prog_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pinIn   ({progModePin, progStrobePinN, progReadPinN, progSigReqPin,
		            progAddrPin, progDataPinIn}),
		.resetVal({1'b0, 1'b1, 1'b1, 1'b0, 15'h0000, 8'h00}),
		.pinOut  (pins)
	);

	pin_sync3 #(
		.WIDTH(2)
	) u_ctl_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pinIn   ({resetPinN, powerOnPin}),
		.resetVal(2'h2),
		.pinOut  (ctlSync)
	);

	osc_wait_timer #(
		.WAIT_14(WAIT_14),
		.WAIT_17(WAIT_17),
		.WAIT_18(WAIT_18)
	) u_wait (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.start  (st_ff.waitStart),
		.sel    (st_ff.cfg.oscSel),
		.done   (waitDone)
	);

	// ------------------------------------------------------------
	// option decode
	// ------------------------------------------------------------
	function automatic otp_option_pkg::cfg_s decode(
		input logic [`OPT_BYTES-1:0][7:0] m
	);
		otp_option_pkg::cfg_s c;
		logic [7:0] p1;
		logic [7:0] p4;
		c            = '0;
		c.oscSel     = m[`OPT_IDX_SYS][`OPT_OSC_LSB +: 2];
		c.resetPinEn = m[`OPT_IDX_SYS][`OPT_RSTPIN_BIT];
		c.porEn      = m[`OPT_IDX_SYS][`OPT_POR_BIT];
		// pins without an option bit never get a pull-up; vacant bits are ignored
		p1           = ~m[`OPT_IDX_P1];
		p1[7:6]      = 2'h0;
		p1[2]        = 1'b0;
		c.pull1En    = p1;
		c.pull3En    = ~m[`OPT_IDX_P3];
		p4           = ~m[`OPT_IDX_P4];
		p4[4]        = 1'b0;
		c.pull4En    = p4;
		c.pull7En    = {~m[`OPT_IDX_P7HI][1:0], ~m[`OPT_IDX_P7LO][4:0]};
		c.pull0En    = {{4{~m[`OPT_IDX_P0][`OPT_P0HI_BIT]}},
		                {4{~m[`OPT_IDX_P0][`OPT_P0LO_BIT]}}};
		return c;
	endfunction : decode

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic        strobeFall;
		logic        porRise;
		logic        isOpt;
		logic [15:0] chipAddr;
		strobeFall = 1'b0;
		porRise    = 1'b0;
		isOpt      = 1'b0;
		chipAddr   = 16'h0000;

		nxt_st            = st_ff;
		nxt_st.memWe      = 1'b0;
		nxt_st.memRe      = 1'b0;
		nxt_st.waitStart  = 1'b0;
		nxt_st.strobePrev = pins.strobeN;
		nxt_st.porPrev    = ctlSync[0];

		strobeFall = st_ff.strobePrev & ~pins.strobeN;
		porRise    = ~st_ff.porPrev & ctlSync[0];
		isOpt      = pins.addr <= `OPT_LAST_ADDR;
		chipAddr   = `PROG_OFFSET | {1'b0, pins.addr};

		// programming port
		if (pins.mode && strobeFall) begin
			if (isOpt) begin
				// one-time cells only move from one to zero
				nxt_st.optMem[pins.addr[2:0]] = st_ff.optMem[pins.addr[2:0]]
				                                & pins.data;
			end else begin
				nxt_st.memWe    = 1'b1;
				nxt_st.memAddr  = chipAddr;
				nxt_st.memWdata = pins.data;
			end
		end else if (pins.mode && !pins.readN) begin
			nxt_st.memRe     = ~isOpt;
			nxt_st.memAddr   = chipAddr;
			nxt_st.rdFromOpt = isOpt;
			nxt_st.rdIdx     = pins.addr[2:0];
			nxt_st.rdSig     = pins.sigReq;
		end
		nxt_st.progDataOe = pins.mode & ~pins.readN;
		// no signature table exists; a signature query gets blank data
		if (st_ff.rdSig) begin
			nxt_st.progDataOut = `OPT_BLANK;
		end else if (st_ff.rdFromOpt) begin
			// vacant bits return the stored value, one unless programmed
			nxt_st.progDataOut = st_ff.optMem[st_ff.rdIdx];
		end else begin
			nxt_st.progDataOut = memRdata;
		end

		// stabilization wait sequencing
		case (st_ff.phase)
			otp_option_pkg::PH_IDLE: begin
				if (st_ff.cfg.porEn && porRise) begin
					nxt_st.phase     = otp_option_pkg::PH_WAIT_POR;
					nxt_st.waitStart = 1'b1;
				end else if (stopWake) begin
					nxt_st.phase     = otp_option_pkg::PH_WAIT_STOP;
					nxt_st.waitStart = 1'b1;
				end
			end
			otp_option_pkg::PH_WAIT_POR,
			otp_option_pkg::PH_WAIT_STOP: begin
				if (waitDone) begin
					nxt_st.phase = otp_option_pkg::PH_IDLE;
				end
			end
			default: begin
				nxt_st.phase = otp_option_pkg::PH_IDLE;
			end
		endcase
		nxt_st.oscStable = nxt_st.phase == otp_option_pkg::PH_IDLE;
		// reset pin only asserts reset when its function is fitted
		nxt_st.resetReq  = (st_ff.cfg.resetPinEn & ~ctlSync[1])
		                   | (nxt_st.phase == otp_option_pkg::PH_WAIT_POR);

		if (!otpBlankn) begin
			nxt_st.optMem = {`OPT_BYTES{`OPT_BLANK}};
		end

		// options follow the array only while reset is held; frozen when running
		if (!resetn) begin
			nxt_st.cfg         = decode(st_ff.optMem);
			nxt_st.phase       = otp_option_pkg::PH_IDLE;
			nxt_st.strobePrev  = 1'b1;
			nxt_st.porPrev     = 1'b0;
			nxt_st.rdFromOpt   = 1'b0;
			nxt_st.rdIdx       = 3'h0;
			nxt_st.rdSig       = 1'b0;
			nxt_st.memAddr     = 16'h0000;
			nxt_st.memWdata    = 8'h00;
			nxt_st.memWe       = 1'b0;
			nxt_st.memRe       = 1'b0;
			nxt_st.progDataOut = 8'h00;
			nxt_st.progDataOe  = 1'b0;
			nxt_st.resetReq    = 1'b1;
			nxt_st.oscStable   = 1'b1;
			nxt_st.waitStart   = 1'b0;
		end
	end

	// the array is not cleared by reset: it models non-volatile cells
	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign progDataPinOut = st_ff.progDataOut;
	assign progDataPinOe  = st_ff.progDataOe;
	assign memAddr        = st_ff.memAddr;
	assign memWdata       = st_ff.memWdata;
	assign memWe          = st_ff.memWe;
	assign memRe          = st_ff.memRe;
	assign resetReq       = st_ff.resetReq;
	assign oscStable      = st_ff.oscStable;
	assign oscWaitSel     = st_ff.cfg.oscSel;
	assign resetPinEn     = st_ff.cfg.resetPinEn;
	assign porEn          = st_ff.cfg.porEn;
	assign pull0En        = st_ff.cfg.pull0En;
	assign pull1En        = st_ff.cfg.pull1En;
	assign pull3En        = st_ff.cfg.pull3En;
	assign pull4En        = st_ff.cfg.pull4En;
	assign pull7En        = st_ff.cfg.pull7En;

endmodule : one_time_prog_memory_option_decode

/* File: verif/one_time_prog_memory_option_properties.sv */
`timescale 1ns/1ps

// ------
// option decode checks
// ------
module one_time_prog_memory_option_checker #(
	parameter int WAIT_14 = 16384,
	parameter int WAIT_17 = 131072,
	parameter int WAIT_18 = 262144
) (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        resetPinN,
	input wire logic        powerOnPin,
	input wire logic        stopWake,
	input wire logic        resetReq,
	input wire logic        oscStable,
	input wire logic [1:0]  oscWaitSel,
	input wire logic        resetPinEn,
	input wire logic        porEn,
	input wire logic [15:0] memAddr,
	input wire logic        memWe,
	input wire logic        memRe,
	input wire logic [7:0]  pull0En,
	input wire logic [7:0]  pull1En,
	input wire logic [7:0]  pull3En,
	input wire logic [7:0]  pull4En,
	input wire logic [6:0]  pull7En
);
	logic [18:0] lowCnt_ff;
	logic [18:0] nxt_lowCnt;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// cleared by reset, so a wait cut short is not measured
	always_comb nxt_lowCnt = (!resetn || oscStable) ? 19'h0 : lowCnt_ff + 19'h1;
	always_ff @(posedge clk_sys) lowCnt_ff <= nxt_lowCnt;

	function automatic int waitLen(input logic [1:0] sel);
		return (sel == 2'h0) ? 16 : (sel == 2'h1) ? WAIT_14 : (sel == 2'h2) ? WAIT_17 : WAIT_18;
	endfunction : waitLen

	sequence pinHeld;
		(resetPinEn && !resetPinN) [*7];
	endsequence
	sequence porEdge;
		porEn && oscStable && $rose(powerOnPin);
	endsequence

	a_wake_starts_wait: assert property (stopWake && oscStable |=> !oscStable)
		else $error("stop wake started no wait");
	a_wait_exact_length: assert property (
		$rose(oscStable) |-> int'(lowCnt_ff) == waitLen(oscWaitSel) + 2)
		else $error("wait length wrong");
	a_por_starts_wait: assert property (
		porEdge |-> ##[2:8] (resetReq && !oscStable))
		else $error("power-on started no reset wait");
	a_pin_gives_reset: assert property (pinHeld |-> resetReq)
		else $error("reset pin ignored");
	a_array_offset: assert property ((memWe || memRe) |-> memAddr[15])
		else $error("array access without offset");
	a_write_one_cycle: assert property ($rose(memWe) |=> !memWe)
		else $error("array write strobe too long");
	a_options_frozen: assert property ($past(resetn) |-> $stable(
		{oscWaitSel, resetPinEn, porEn, pull0En, pull1En, pull3En, pull4En, pull7En}))
		else $error("options changed while running");
	a_port0_groups: assert property (
		pull0En[3:0] inside {4'h0, 4'hf} && pull0En[7:4] inside {4'h0, 4'hf})
		else $error("port 0 pull-up group split");
	a_no_option_pulls: assert property (
		pull1En[2] == 1'b0 && pull1En[7:6] == 2'h0 && pull4En[4] == 1'b0)
		else $error("pull-up without option bit");
endmodule : one_time_prog_memory_option_checker

bind one_time_prog_memory_option_decode one_time_prog_memory_option_checker #(
	.WAIT_14(WAIT_14), .WAIT_17(WAIT_17), .WAIT_18(WAIT_18)
) checks (
	.clk_sys, .resetn, .resetPinN, .powerOnPin, .stopWake, .resetReq, .oscStable,
	.oscWaitSel, .resetPinEn, .porEn, .memAddr, .memWe, .memRe,
	.pull0En, .pull1En, .pull3En, .pull4En, .pull7En
);

/* File: verif/prog_model.sv */
`timescale 1ns/1ps

// ------
// programmer and program array
// ------
module prog_model (
	input  wire logic                  clk_sys,
	input  wire logic [7:0]            dataOut,
	input  wire logic                  dataOe,
	input  wire logic [15:0]           memAddr,
	input  wire logic [7:0]            memWdata,
	input  wire logic                  memWe,
	input  wire logic                  memRe,
	output otp_option_pkg::prog_pins_s pins,
	output wire logic [7:0]            dataBus,
	output logic      [7:0]            memRdata
);
	logic [7:0] arr [logic [15:0]];
	logic [7:0] junk = 8'ha5;
	logic       drvEn = 1'b0;

	initial begin
		pins = '{mode: 1'b0, strobeN: 1'b1, readN: 1'b1, sigReq: 1'b0, addr: 15'h0, data: 8'h0};
		memRdata = 8'h0;
	end

	// released data lines wander rather than keep the last byte
	assign dataBus = dataOe ? dataOut : drvEn ? pins.data : junk;

	always @(posedge clk_sys) begin
		junk <= {junk[6:0], ~junk[7]};
		memRdata <= ~memRdata;
		if (memRe)
			memRdata <= arr.exists(memAddr) ? arr[memAddr] : 8'hff;
		if (memWe)
			arr[memAddr] = memWdata;
	end

	function automatic logic [7:0] vacant(input logic [14:0] a);
		case (a)
			15'h0, 15'h6: return 8'hf0;
			15'h1: return 8'hc4;
			15'h3: return 8'h10;
			15'h4: return 8'hff;
			15'h5: return 8'he0;
			default: return 8'h00;
		endcase
	endfunction : vacant

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step

	// six cycles of settle cover the three-stage pin synchronizers
	task automatic pwrite(input logic [14:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		pins.mode <= 1'b1;
		pins.addr <= a;
		pins.data <= d | vacant(a);
		drvEn <= 1'b1;
		step(6);
		pins.strobeN <= 1'b0;
		step(8);
		pins.strobeN <= 1'b1;
		step(6);
		pins.mode <= 1'b0;
		drvEn <= 1'b0;
	endtask : pwrite

	// a signature answer is only compared, never used to pick the part
	task automatic pread(input logic [14:0] a, input logic s, output logic [7:0] d);
		@(posedge clk_sys);
		pins.mode <= 1'b1;
		pins.addr <= a;
		pins.sigReq <= s;
		step(6);
		pins.readN <= 1'b0;
		step(8);
		d = dataBus;
		pins.readN <= 1'b1;
		pins.sigReq <= 1'b0;
		step(6);
		pins.mode <= 1'b0;
	endtask : pread
endmodule : prog_model

/* File: verif/tb.sv */
`timescale 1ns/1ps

module tb;
	localparam int W14 = 20;
	localparam int W17 = 40;
	localparam int W18 = 60;
	localparam int WT [4] = '{16, W14, W17, W18};

	logic                       clk_sys, resetn, otpBlankn, resetPinN, powerOnPin, stopWake;
	logic                       progDataPinOe, memWe, memRe, resetReq, oscStable;
	logic [7:0]                 progDataPinOut, memWdata, rdVal;
	logic [15:0]                memAddr;
	logic [6:0][7:0]            opt;
	wire logic [7:0]            dataBus, memRdata;
	wire otp_option_pkg::prog_pins_s pins;
	wire otp_option_pkg::cfg_s  cfg;
	int                         nMismatch, samplesChecked, weCount;
	logic [7:0]                 pat [7] = '{8'hf2, 8'hd5, 8'h5a, 8'h3c, 8'hff, 8'hea, 8'hf9};

	one_time_prog_memory_option_decode #(.WAIT_14(W14), .WAIT_17(W17), .WAIT_18(W18)) dut (
		.clk_sys, .resetn, .otpBlankn, .progModePin(pins.mode), .progStrobePinN(pins.strobeN),
		.progReadPinN(pins.readN), .progSigReqPin(pins.sigReq), .progAddrPin(pins.addr),
		.progDataPinIn(dataBus), .progDataPinOut, .progDataPinOe, .memAddr, .memWdata,
		.memWe, .memRe, .memRdata, .resetPinN, .powerOnPin, .stopWake, .resetReq, .oscStable,
		.oscWaitSel(cfg.oscSel), .resetPinEn(cfg.resetPinEn), .porEn(cfg.porEn),
		.pull0En(cfg.pull0En), .pull1En(cfg.pull1En), .pull3En(cfg.pull3En),
		.pull4En(cfg.pull4En), .pull7En(cfg.pull7En)
	);
	prog_model prog (
		.clk_sys, .dataOut(progDataPinOut), .dataOe(progDataPinOe), .memAddr, .memWdata,
		.memWe, .memRe, .pins, .dataBus, .memRdata
	);

	// ------
	// helpers
	// ------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
		if (memWe === 1'b1)
			weCount <= weCount + 1;

	function automatic otp_option_pkg::cfg_s decode(input logic [6:0][7:0] b);
		return '{b[0][1:0], b[0][3], b[0][2], {{4{~b[6][3]}}, {4{~b[6][2]}}}, ~b[1] & 8'h3b,
			~b[2], ~b[3] & 8'hef, {~b[6][1:0], ~b[5][4:0]}};
	endfunction : decode

	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : step

	task automatic rst(input logic blank);
		@(posedge clk_sys);
		resetn <= 1'b0;
		otpBlankn <= !blank;
		step(8);
		resetn <= 1'b1;
		otpBlankn <= 1'b1;
		if (blank)
			opt = '1;
		step(2);
	endtask : rst

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		prog.pwrite(a, d);
		if (a < 15'h7)
			opt[a[2:0]] = opt[a[2:0]] & d;
	endtask : wr

	task automatic rdChk(input logic [14:0] a, input logic s, input logic [7:0] e);
		prog.pread(a, s, rdVal);
		chk("read data", rdVal, e);
	endtask : rdChk

	task automatic waitTest(input logic por, input int exp);
		int n;
		int r;
		n = 0;
		r = 0;
		@(posedge clk_sys);
		if (por)
			powerOnPin <= 1'b1;
		else
			stopWake <= 1'b1;
		repeat (100) begin
			@(posedge clk_sys);
			stopWake <= 1'b0;
			n += int'(oscStable === 1'b0);
			r += int'(oscStable === 1'b0 && resetReq === 1'b1);
		end
		powerOnPin <= 1'b0;
		chk("wait cycles", n, exp);
		if (por)
			chk("reset during wait", r, exp);
		step(4);
	endtask : waitTest

	task automatic pinTest(input logic e);
		@(posedge clk_sys);
		resetPinN <= 1'b0;
		step(10);
		chk("pin reset", resetReq, e);
		resetPinN <= 1'b1;
		step(10);
	endtask : pinTest

	task automatic wrapUp();
		if (nMismatch == 0 && samplesChecked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrapUp

	// ------
	// tests
	// ------
	initial begin
		resetn = 1'b0;
		otpBlankn = 1'b0;
		resetPinN = 1'b1;
		powerOnPin = 1'b0;
		stopWake = 1'b0;
		nMismatch = 0;
		samplesChecked = 0;
		weCount = 0;
		rst(1'b1);
		chk("cfg", cfg, decode(opt));
		rdChk(15'h0, 1'b0, 8'hff);
		// start pulse and done pulse each add one registered cycle to the count
		waitTest(1'b0, WT[3] + 2);
		waitTest(1'b1, WT[3] + 2);
		pinTest(1'b1);
		for (int a = 0; a < 7; a++)
			wr(15'(a), pat[a]);
		chk("cfg", cfg, decode('1));
		chk("array writes", weCount, 0);
		rst(1'b0);
		chk("cfg", cfg, decode(opt));
		for (int a = 0; a < 7; a++)
			rdChk(15'(a), 1'b0, pat[a]);
		waitTest(1'b0, WT[2] + 2);
		waitTest(1'b1, 0);
		pinTest(1'b0);
		wr(15'h0007, 8'h3c);
		chk("array address", memAddr, 16'h8007);
		chk("array data", memWdata, 8'h3c);
		wr(15'h7fff, 8'hc3);
		chk("array address", memAddr, 16'hffff);
		chk("array writes", weCount, 2);
		rdChk(15'h0007, 1'b0, 8'h3c);
		rdChk(15'h7fff, 1'b0, 8'hc3);
		rdChk(15'h0000, 1'b1, 8'hff);
		for (int c = 1; c >= 0; c--) begin
			rst(1'b1);
			wr(15'h0, 8'hfc | 8'(c));
			rst(1'b0);
			waitTest(1'b0, WT[c] + 2);
		end
		wrapUp();
	end

	// about three times the expected run
	initial begin
		#200000;
		nMismatch++;
		wrapUp();
	end
endmodule : tb
